/* core/ccd_clock_config.sv */
/*
 * codec sample-rate clock configuration: dac oversampling, dac
 * instruction count and interpolation, two adc dividers with power
 * down, adc oversampling.
 * assumes: register port and dac modulator clock come from logic on
 * clk; the block-select field lives in another register outside.
 */
`timescale 1ns/1ps

// Overview of operation
// [R1] dac oversampling ratio is 10 bits; zero means 1024, else value
// [R2] upper two ratio bits come from low two bits of previous register
// [R3] software keeps dac oversampling a multiple of interpolation ratio
// [R4] instruction count is four times code; zero means 1024
// [R5] software keeps instruction count a multiple of interpolation ratio
// [R6] instruction count and interpolation apply only when block select is zero
// [R7] interpolation field gives ratio equal value; zero gives 16
// [R8] software never writes upper interpolation bits nor the reserved register
// [R9] first adc divider bit 7 clear powers it down, adc clock follows dac
// [R10] first adc divider divides by value; zero means 128
// [R11] second adc divider bit 7 clear powers it down, adc clock follows dac
// [R12] second adc divider divides by value; zero means 128
// [R13] adc oversampling codes decode to 256, 32, 64, 128; others flagged
// [R14] software pairs adc oversampling ratio with matching filter type
// [R15] software keeps adc oversampling a multiple of decimation ratio
// [R16] each divider gives one period per count, changes without runt pulses
module ccd_clock_config
  import ccd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic [4:0] blockSelect,
  input wire logic dacModClock,
  input wire logic dacModTick,
  output logic [10:0] dacOversamplingRatio,
  output logic [10:0] dacInstructionCount,
  output logic [4:0] dacInterpolationRatio,
  output logic dacProgramValid,
  output logic [8:0] adcOversamplingValue,
  output logic adcOversamplingBad,
  output logic adcModulatorClock,
  output logic adcModulatorTick
);
  `include "ccd_defines.svh"

  // ****************************************************************
  // state and sub-block connections
  // ****************************************************************
  ccd_top_s st;
  ccd_top_s next_st;
  logic firstUp;
  logic secondUp;
  logic bothUp;

  ccd_cfg_if cfg ();
  ccd_div_if firstDiv ();
  ccd_div_if secondDiv ();

  // ****************************************************************
  // decoder and divider chain
  // ****************************************************************

  // ratio decode of the stored codes
  assign cfg.dacOsrCode = {st.osrHigh, st.osrLow}; // [R2]
  assign cfg.instrCode = st.instr;
  assign cfg.interpCode = st.interp;
  assign cfg.adcOsrCode = st.adcOsr;

  ccd_ratio_decode u_decode (
    .cfg(cfg)
  );

  // power bits of the two adc dividers
  assign firstUp = st.firstDiv[`CCD_DIV_POWER_BIT]; // [R9]
  assign secondUp = st.secondDiv[`CCD_DIV_POWER_BIT]; // [R11]
  assign bothUp = firstUp && secondUp;

  // first divider runs on every codec input clock
  assign firstDiv.tickIn = 1'b1;
  assign firstDiv.powerUp = firstUp; // [R9]
  assign firstDiv.divCode = st.firstDiv[`CCD_DIV_VALUE_MSB:0]; // [R10]

  ccd_divider u_first_div (
    .clk(clk),
    .rst_b(rst_b),
    .port(firstDiv)
  );

  // second divider counts output periods of the first
  assign secondDiv.tickIn = firstDiv.tickOut;
  assign secondDiv.powerUp = secondUp; // [R11]
  assign secondDiv.divCode = st.secondDiv[`CCD_DIV_VALUE_MSB:0]; // [R12]

  ccd_divider u_second_div (
    .clk(clk),
    .rst_b(rst_b),
    .port(secondDiv)
  );

  // ****************************************************************
  // next-state logic
  // ****************************************************************

  // register writes, read data and registered outputs
  always_comb begin
    next_st = st;

    // register writes; reserved bits are never stored
    if (regWrite) begin
      case (regAddr)
        `CCD_OFS_DAC_OSR_HIGH: begin
          next_st.osrHigh = regWdata[`CCD_OSR_HIGH_MSB:0]; // [R2]
        end
        `CCD_OFS_DAC_OSR_LOW: begin
          next_st.osrLow = regWdata; // [R1]
        end
        `CCD_OFS_DAC_INSTR: begin
          next_st.instr = regWdata; // [R4]
        end
        `CCD_OFS_DAC_INTERP: begin
          next_st.interp = regWdata[`CCD_INTERP_MSB:0]; // [R7]
        end
        `CCD_OFS_ADC_FIRST_DIV: begin
          next_st.firstDiv = regWdata;
        end
        `CCD_OFS_ADC_SECOND_DIV: begin
          next_st.secondDiv = regWdata;
        end
        `CCD_OFS_ADC_OSR: begin
          next_st.adcOsr = regWdata;
        end
        default: begin
          next_st = st; // reserved and unknown numbers ignore writes
        end
      endcase
    end

    // read data follows the address one cycle later
    case (regAddr)
      `CCD_OFS_DAC_OSR_HIGH: begin
        next_st.rdData = {6'h00, st.osrHigh};
      end
      `CCD_OFS_DAC_OSR_LOW: begin
        next_st.rdData = st.osrLow;
      end
      `CCD_OFS_DAC_INSTR: begin
        next_st.rdData = st.instr;
      end
      `CCD_OFS_DAC_INTERP: begin
        next_st.rdData = {4'h0, st.interp};
      end
      `CCD_OFS_ADC_FIRST_DIV: begin
        next_st.rdData = st.firstDiv;
      end
      `CCD_OFS_ADC_SECOND_DIV: begin
        next_st.rdData = st.secondDiv;
      end
      `CCD_OFS_ADC_OSR: begin
        next_st.rdData = st.adcOsr;
      end
      default: begin
        next_st.rdData = 8'h00;
      end
    endcase

    // dac oversampling ratio always applies
    next_st.dacOsr = cfg.dacOsr; // [R1]

    // programmed dac engine values apply only in direct block mode
    next_st.dacValid = (blockSelect == `CCD_BLOCK_SEL_DIRECT); // [R6]
    if (next_st.dacValid) begin
      next_st.dacInstr = cfg.dacInstr; // [R4] [R6]
      next_st.dacInterp = cfg.dacInterp; // [R7] [R6]
    end else begin
      next_st.dacInstr = 11'h000; // [R6]
      next_st.dacInterp = 5'h00; // [R6]
    end

    // adc oversampling value and misuse flag
    next_st.adcOsrVal = cfg.adcOsr; // [R13]
    next_st.adcOsrBad = cfg.adcOsrBad; // [R13]

    // adc modulator clock: divided, or the dac clock when powered down
    if (bothUp) begin
      next_st.adcModClock = secondDiv.level; // [R16]
      next_st.adcModTick = secondDiv.tickOut; // [R16]
    end else begin
      next_st.adcModClock = dacModClock; // [R9] [R11]
      next_st.adcModTick = dacModTick; // [R9] [R11]
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************

  // reset loads the documented defaults
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.osrHigh <= `CCD_RST_DAC_OSR_HIGH;
      st.osrLow <= `CCD_RST_DAC_OSR_LOW;
      st.instr <= `CCD_RST_DAC_INSTR;
      st.interp <= `CCD_RST_DAC_INTERP;
      st.firstDiv <= `CCD_RST_ADC_DIV;
      st.secondDiv <= `CCD_RST_ADC_DIV;
      st.adcOsr <= `CCD_RST_ADC_OSR;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // outputs, all from flops
  // ****************************************************************
  assign regRdata = st.rdData;
  assign dacOversamplingRatio = st.dacOsr;
  assign dacInstructionCount = st.dacInstr;
  assign dacInterpolationRatio = st.dacInterp;
  assign dacProgramValid = st.dacValid;
  assign adcOversamplingValue = st.adcOsrVal;
  assign adcOversamplingBad = st.adcOsrBad;
  assign adcModulatorClock = st.adcModClock;
  assign adcModulatorTick = st.adcModTick;

endmodule // ccd_clock_config

/* core/ccd_defines.svh */
/*
 * register numbers, field positions and reset values of the codec
 * sample-rate clock configuration block.
 * assumes: included by bare name from the top module and the ratio decoder.
 */
`ifndef CCD_DEFINES_SVH
`define CCD_DEFINES_SVH

// ****************************************************************
// register numbers on the control port
// ****************************************************************
`define CCD_OFS_DAC_OSR_HIGH 8'h0d
`define CCD_OFS_DAC_OSR_LOW 8'h0e
`define CCD_OFS_DAC_INSTR 8'h0f
`define CCD_OFS_DAC_INTERP 8'h10
`define CCD_OFS_RSVD_17 8'h11
`define CCD_OFS_ADC_FIRST_DIV 8'h12
`define CCD_OFS_ADC_SECOND_DIV 8'h13
`define CCD_OFS_ADC_OSR 8'h14

// ****************************************************************
// reset values
// ****************************************************************
`define CCD_RST_DAC_OSR_HIGH 2'h0
`define CCD_RST_DAC_OSR_LOW 8'h80
`define CCD_RST_DAC_INSTR 8'h80
`define CCD_RST_DAC_INTERP 4'h8
`define CCD_RST_ADC_DIV 8'h01
`define CCD_RST_ADC_OSR 8'h80

// ****************************************************************
// field positions and codes
// ****************************************************************
`define CCD_DIV_POWER_BIT 7
`define CCD_DIV_VALUE_MSB 6
`define CCD_INTERP_MSB 3
`define CCD_OSR_HIGH_MSB 1
`define CCD_ADC_OSR_CODE_256 8'h00
`define CCD_ADC_OSR_CODE_32 8'h20
`define CCD_ADC_OSR_CODE_64 8'h40
`define CCD_ADC_OSR_CODE_128 8'h80
`define CCD_BLOCK_SEL_DIRECT 5'h00

`endif

/* core/ccd_pkg.sv */
/*
 * types shared by the clock configuration modules.
 * assumes: compiled before the interface and the modules.
 */
package ccd_pkg;

  // divider state: position in period, latched period, outputs
  typedef struct packed {
    logic [7:0] count;
    logic [7:0] period;
    logic level;
    logic tick;
  } ccd_div_s;

  // top-level state: registers, read data and registered outputs
  typedef struct packed {
    logic [1:0] osrHigh;
    logic [7:0] osrLow;
    logic [7:0] instr;
    logic [3:0] interp;
    logic [7:0] firstDiv;
    logic [7:0] secondDiv;
    logic [7:0] adcOsr;
    logic [7:0] rdData;
    logic [10:0] dacOsr;
    logic [10:0] dacInstr;
    logic [4:0] dacInterp;
    logic dacValid;
    logic [8:0] adcOsrVal;
    logic adcOsrBad;
    logic adcModClock;
    logic adcModTick;
  } ccd_top_s;

endpackage

/* core/ccd_if.sv */
/*
 * interfaces between the top module, its decoder and its dividers.
 * assumes: all signals on the one core clock.
 */
`timescale 1ns/1ps

// raw register fields out, decoded ratios back
interface ccd_cfg_if;
  logic [9:0] dacOsrCode;
  logic [7:0] instrCode;
  logic [3:0] interpCode;
  logic [7:0] adcOsrCode;
  logic [10:0] dacOsr;
  logic [10:0] dacInstr;
  logic [4:0] dacInterp;
  logic [8:0] adcOsr;
  logic adcOsrBad;
  modport top (output dacOsrCode, instrCode, interpCode, adcOsrCode,
    input dacOsr, dacInstr, dacInterp, adcOsr, adcOsrBad);
  modport dec (input dacOsrCode, instrCode, interpCode, adcOsrCode,
    output dacOsr, dacInstr, dacInterp, adcOsr, adcOsrBad);
endinterface // ccd_cfg_if

// one divider: input ticks, divide code, power, divided clock
interface ccd_div_if;
  logic tickIn;
  logic powerUp;
  logic [6:0] divCode;
  logic tickOut;
  logic level;
  modport top (output tickIn, powerUp, divCode, input tickOut, level);
  modport div (input tickIn, powerUp, divCode, output tickOut, level);
endinterface // ccd_div_if

/* core/ccd_ratio_decode.sv */
/*
 * combinational decode of programmed codes into ratios.
 * assumes: codes come from registers of the top module.
 */
`timescale 1ns/1ps

module ccd_ratio_decode
  import ccd_pkg::*;
(
  ccd_cfg_if.dec cfg
);
  `include "ccd_defines.svh"

  // zero codes select the ratio one above the field range
  always_comb begin
    cfg.dacOsr = {cfg.dacOsrCode == 10'h000, cfg.dacOsrCode}; // [R1]
    cfg.dacInstr = {cfg.instrCode == 8'h00, cfg.instrCode, 2'h0}; // [R4]
    cfg.dacInterp = {cfg.interpCode == 4'h0, cfg.interpCode}; // [R7]
    case (cfg.adcOsrCode) // [R13]
      `CCD_ADC_OSR_CODE_256: begin
        cfg.adcOsr = 9'h100;
        cfg.adcOsrBad = 1'b0;
      end
      `CCD_ADC_OSR_CODE_32, `CCD_ADC_OSR_CODE_64, `CCD_ADC_OSR_CODE_128: begin
        cfg.adcOsr = {1'b0, cfg.adcOsrCode};
        cfg.adcOsrBad = 1'b0;
      end
      default: begin
        cfg.adcOsr = {1'b0, cfg.adcOsrCode};
        cfg.adcOsrBad = 1'b1;
      end
    endcase
  end

endmodule // ccd_ratio_decode

/* core/ccd_divider.sv */
/*
 * integer clock divider, 1 to 128, on input ticks.
 * assumes: tickIn is a one-cycle enable on the core clock.
 */
`timescale 1ns/1ps

module ccd_divider
  import ccd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  ccd_div_if.div port
);

  ccd_div_s st;
  ccd_div_s next_st;
  logic [7:0] code8;
  logic [7:0] lastCount;
  logic [7:0] usePeriod;

  // one output period per programmed count of input ticks
  always_comb begin
    code8 = {port.divCode == 7'h00, port.divCode}; // [R10] [R12]
    lastCount = st.period - 8'h01;
    usePeriod = st.period;
    next_st = st;
    next_st.tick = 1'b0;
    if (!port.powerUp) begin
      next_st.count = 8'h00;
      next_st.period = code8;
      next_st.level = 1'b0;
    end else if (port.tickIn) begin
      if (st.count == lastCount) begin
        next_st.count = 8'h00;
        next_st.tick = 1'b1; // [R16]
        next_st.period = code8; // new value only at a period boundary [R16]
        usePeriod = code8;
      end else begin
        next_st.count = st.count + 8'h01;
      end
      // high for the first half of each period
      next_st.level = (usePeriod == 8'h01) ||
        (next_st.count < ((usePeriod + 8'h01) >> 1)); // [R16]
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign port.tickOut = st.tick;
  assign port.level = st.level;

endmodule // ccd_divider

/* testbench/ccd_clock_config_properties.sv */
/*
 * port properties of the clock configuration block, and their bind.
 * assumes: register writes on the port are the only way to program it.
 */
`timescale 1ns/1ps

module ccd_clock_config_properties
  import ccd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic [4:0] blockSelect,
  input wire logic dacModClock,
  input wire logic dacModTick,
  input wire logic [10:0] dacOversamplingRatio,
  input wire logic [10:0] dacInstructionCount,
  input wire logic [4:0] dacInterpolationRatio,
  input wire logic dacProgramValid,
  input wire logic [8:0] adcOversamplingValue,
  input wire logic adcOversamplingBad,
  input wire logic adcModulatorClock,
  input wire logic adcModulatorTick
);
  logic [1:0] pw;
  logic [6:0] n1, n2;
  logic [7:0] d1, d2;
  logic [1:0] ticks;
  logic [15:0] gap, prod;

  // ****************************************************************
  // mirror of divider settings and tick spacing
  // ****************************************************************
  // code zero divides by 128
  assign d1 = (n1 == 7'h00) ? 8'h80 : {1'b0, n1};
  assign d2 = (n2 == 7'h00) ? 8'h80 : {1'b0, n2};
  assign prod = {8'h00, d1} * {8'h00, d2};

  // ticks since last divider write, saturating; gap since last tick
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pw <= 2'h0;
      n1 <= 7'h01;
      n2 <= 7'h01;
      ticks <= 2'h0;
      gap <= 16'h0000;
    end else begin
      if (regWrite && regAddr == 8'h12)
        {pw[0], n1} <= regWdata;
      if (regWrite && regAddr == 8'h13)
        {pw[1], n2} <= regWdata;
      if (regWrite && regAddr[7:1] == 7'h09)
        ticks <= 2'h0;
      else if (adcModulatorTick && ticks != 2'h3)
        ticks <= ticks + 2'h1;
      gap <= adcModulatorTick ? 16'h0001 : gap + 16'h0001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ****************************************************************
  // properties
  // ****************************************************************
  AST_VALID: assert property ($past(rst_b) |->
    dacProgramValid == ($past(blockSelect) == 5'h00))
    else $error("program valid does not follow block select");
  AST_GATE: assert property (!dacProgramValid |->
    dacInstructionCount == 11'h000 && dacInterpolationRatio == 5'h00)
    else $error("instruction or interpolation shown while not valid");
  AST_INTERP: assert property (dacProgramValid |->
    dacInterpolationRatio inside {[5'h01:5'h10]})
    else $error("interpolation ratio out of range");
  AST_INSTR: assert property (dacProgramValid |->
    dacInstructionCount[1:0] == 2'h0 && dacInstructionCount inside {[11'h004:11'h400]})
    else $error("instruction count not a multiple of four in range");
  AST_DAC_OVERSAMPLING_RATIO: assert property ($past(rst_b) |->
    dacOversamplingRatio inside {[11'h001:11'h400]})
    else $error("dac oversampling ratio out of range");
  AST_ADC_OVERSAMPLING_VALUE: assert property ($past(rst_b) && !adcOversamplingBad |->
    adcOversamplingValue inside {9'h020, 9'h040, 9'h080, 9'h100})
    else $error("legal adc oversampling value wrong");
  AST_BYPASS: assert property ($past(rst_b) && pw != 2'h3 && $past(pw) != 2'h3 |->
    adcModulatorTick == $past(dacModTick) && adcModulatorClock == $past(dacModClock))
    else $error("powered down divider does not pass dac clock");
  AST_PERIOD: assert property (pw == 2'h3 && ticks == 2'h3 && adcModulatorTick |->
    gap == prod)
    else $error("adc tick spacing differs from divide product");
  AST_LEVEL: assert property ($past(pw) == 2'h3 && adcModulatorTick |->
    adcModulatorClock)
    else $error("divided adc clock low at the start of its period");

  // main scenarios reached
  COV_RUN: cover property (pw == 2'h3 && ticks == 2'h3 && adcModulatorTick);
  COV_BAD: cover property (adcOversamplingBad);
  COV_GATE: cover property (!dacProgramValid && $past(dacProgramValid));
endmodule // ccd_clock_config_properties

bind ccd_clock_config ccd_clock_config_properties ccd_clock_config_properties_inst (
  .clk(clk), .rst_b(rst_b), .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata),
  .regRdata(regRdata), .blockSelect(blockSelect), .dacModClock(dacModClock),
  .dacModTick(dacModTick), .dacOversamplingRatio(dacOversamplingRatio),
  .dacInstructionCount(dacInstructionCount), .dacInterpolationRatio(dacInterpolationRatio),
  .dacProgramValid(dacProgramValid), .adcOversamplingValue(adcOversamplingValue),
  .adcOversamplingBad(adcOversamplingBad), .adcModulatorClock(adcModulatorClock),
  .adcModulatorTick(adcModulatorTick));

/* testbench/tb_ccd_clock_config.sv */
/*
 * self-checking bench of the clock configuration block.
 * assumes: write strobe and read data timing of the register port.
 */
`timescale 1ns/1ps

module tb_ccd_clock_config
  import ccd_pkg::*;
;
  logic clk, rst_b, regWrite, dacModClock, dacModTick, valid, aBad, aClk, aTick;
  logic [7:0] regAddr, regWdata, regRdata;
  logic [4:0] blockSelect, interp;
  logic [10:0] dac_oversampling_ratio, instr;
  logic [8:0] adc_oversampling_value;
  logic [1:0] ph;
  int badCount, checkCount, cyc, n, h;
  logic [7:0] rv [8] = '{8'h00, 8'h80, 8'h80, 8'h08, 8'h00, 8'h01, 8'h01, 8'h80};
  logic [7:0] cA [5] = '{8'h00, 8'h01, 8'hfe, 8'hff, 8'h00};
  logic [15:0] eA [5] = '{16'h0400, 16'h0001, 16'h03fe, 16'h03ff, 16'h0100};
  logic [7:0] cB [5] = '{8'h00, 8'h20, 8'h40, 8'h80, 8'h41};
  logic [15:0] eB [5] = '{16'h0100, 16'h0020, 16'h0040, 16'h0080, 16'h0041};
  logic [15:0] pC [4] = '{16'h0006, 16'h0080, 16'h0080, 16'h0001};
  logic [15:0] hC [4] = '{16'h000c, 16'h0200, 16'h0100, 16'h0004};
  logic [7:0] cI [4] = '{8'h00, 8'h01, 8'hff, 8'h80};
  logic [15:0] eI [4] = '{16'h0400, 16'h0004, 16'h03fc, 16'h0200};

  ccd_clock_config ccd_clock_config_inst (.clk(clk), .rst_b(rst_b), .regWrite(regWrite),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .blockSelect(blockSelect),
    .dacModClock(dacModClock), .dacModTick(dacModTick), .dacOversamplingRatio(dac_oversampling_ratio),
    .dacInstructionCount(instr), .dacInterpolationRatio(interp), .dacProgramValid(valid),
    .adcOversamplingValue(adc_oversampling_value), .adcOversamplingBad(aBad), .adcModulatorClock(aClk),
    .adcModulatorTick(aTick));

  // ****************************************************************
  // clock, dac modulator stimulus, timeout
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // dac modulator tick every fourth cycle, clock high half the time
  always @(posedge clk) begin
    #1;
    ph = ph + 2'h1;
    dacModTick = (ph == 2'h0);
    dacModClock = !ph[1];
    cyc++;
    if (cyc == 10000) begin
      badCount++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checkCount++;
    if (got !== exp)
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    if (got !== exp)
      badCount++;
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick();
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    tick();
    regWrite = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    tick();
    regAddr = a;
    tick();
    chk(16'(regRdata), 16'(e));
  endtask

  // counts adc ticks over a window of cycles
  task automatic cnt(input int w);
    n = 0;
    h = 0;
    repeat (w) begin
      tick();
      n += int'(aTick);
      h += int'(aClk);
    end
  endtask

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    {rst_b, regWrite, regAddr, regWdata, blockSelect, ph, dacModTick, dacModClock} = '0;
    {badCount, checkCount, cyc} = '0;
    repeat (4) @(posedge clk);
    #1 rst_b = 1'b1;
    for (int i = 0; i < 8; i++)
      rd(8'h0d + 8'(i), rv[i]);
    chk(16'(dac_oversampling_ratio), 16'h0080);
    chk(16'(instr), 16'h0200);
    chk(16'(interp), 16'h0008);
    chk(16'(adc_oversampling_value), 16'h0080);
    $display("test reset values done");
    wr(8'h10, 8'h01); // ratio 1 divides every oversampling value below
    for (int i = 0; i < 5; i++) begin
      wr(8'h0d, {6'h00, i[1] ? 2'h3 : (i == 4 ? 2'h1 : 2'h0)});
      wr(8'h0e, cA[i]);
      tick();
      chk(16'(dac_oversampling_ratio), eA[i]);
    end
    wr(8'h0d, 8'hff);
    rd(8'h0d, 8'h03);
    wr(8'h0e, 8'hc0); // 960 is a multiple of 16, 15, 8, 4 and 1
    tick();
    chk(16'(dac_oversampling_ratio), 16'h03c0);
    $display("test dac oversampling done");
    for (int i = 0; i < 4; i++) begin
      wr(8'h0f, cI[i]);
      wr(8'h10, {4'h0, i == 3 ? 4'h8 : cA[i][3:0] | {4{i == 2}}});
      tick();
      chk(16'(instr), eI[i]);
      chk(16'(interp), i == 0 ? 16'h0010 : (i == 3 ? 16'h0008 : 16'(i * 14 - 13)));
    end
    wr(8'h10, 8'h04); // upper bits left zero
    rd(8'h10, 8'h04);
    tick();
    blockSelect = 5'h01;
    tick();
    tick();
    chk(16'(valid), 16'h0000);
    chk(16'(instr), 16'h0000);
    chk(16'(interp), 16'h0000);
    blockSelect = 5'h00;
    tick();
    tick();
    chk(16'(valid), 16'h0001);
    $display("test dac program done");
    for (int i = 0; i < 5; i++) begin
      wr(8'h14, cB[i]);
      tick();
      chk(16'(adc_oversampling_value), eB[i]);
      chk(16'(aBad), 16'(i == 4));
    end
    wr(8'h31, 8'h5a); // the reserved register itself is never written
    rd(8'h11, 8'h00);
    wr(8'h30, 8'hff);
    rd(8'h30, 8'h00);
    $display("test adc oversampling done");
    cnt(40);
    chk(16'(n), 16'h000a);
    chk(16'(h), 16'h0014);
    for (int i = 0; i < 4; i++) begin
      wr(8'h12, i == 0 ? 8'h83 : (i == 1 ? 8'h80 : 8'h81));
      wr(8'h13, i == 0 ? 8'h82 : (i == 2 ? 8'h80 : 8'h81));
      repeat (400) tick();
      cnt(4 * int'(pC[i]));
      chk(16'(n), 16'h0004);
      chk(16'(h), hC[i]);
    end
    wr(8'h12, 8'h03);
    repeat (4) tick();
    cnt(40);
    chk(16'(n), 16'h000a);
    chk(16'(h), 16'h0014);
    wr(8'h12, 8'h83);
    wr(8'h13, 8'h02);
    repeat (4) tick();
    cnt(40);
    chk(16'(n), 16'h000a);
    chk(16'(h), 16'h0014);
    $display("test adc dividers done");
    results();
  end
endmodule // tb_ccd_clock_config
